//--- pkg/srp_pkg.sv
`default_nettype none

package srp_pkg;

    // Geometry of the control, monitor and status groups
    localparam int NUM_PORTS  = 2;
    localparam int MAX_STEPS  = 18;
    localparam int CTL_HDR    = 2;
    localparam int STEP_WORDS = 6;
    localparam int CTL_WORDS  = CTL_HDR + STEP_WORDS * MAX_STEPS;
    localparam int MON_WORDS  = 9;
    localparam int STAT_BITS  = 5;
    localparam int WORD_W     = 16;
    localparam int ADDR_W     = 7;
    localparam int MON_IDX_W  = 4;
    localparam int CNT_W      = 32;
    localparam int STEP_W     = 5;

    // Header words of the control block
    localparam int OFS_NSTEPS   = 0;
    localparam int OFS_INT_STEP = 1;

    // Word positions inside one step record
    localparam int FLD_FREQ      = 0;
    localparam int FLD_CHG_TIME  = 1;
    localparam int FLD_PRESET_HI = 2;
    localparam int FLD_PRESET_LO = 3;
    localparam int FLD_OPTION    = 4;
    localparam int FLD_RSVD      = 5;

    // Monitor word indices
    localparam int MON_STEP      = 0;
    localparam int MON_CNT_HI    = 1;
    localparam int MON_CNT_LO    = 2;
    localparam int MON_PRESET_HI = 3;
    localparam int MON_PRESET_LO = 4;
    localparam int MON_FREQ      = 5;
    localparam int MON_CHG_TIME  = 6;
    localparam int MON_NSTEPS    = 7;
    localparam int MON_INT_STEP  = 8;

    // Status flag positions
    localparam int STB_OUT_ON   = 0;
    localparam int STB_DIR      = 1;
    localparam int STB_COMPLETE = 2;
    localparam int STB_ERROR    = 3;
    localparam int STB_INT_SEEN = 4;

    // Reference clock rate
    localparam int REF_CLK_HZ = 125_000_000;

    // Initial values loaded by the initialize input
    localparam logic [WORD_W-1:0] INIT_NSTEPS    = 16'h0001;
    localparam logic [WORD_W-1:0] INIT_INT_STEP  = 16'h0001;
    localparam logic [WORD_W-1:0] INIT_FREQ      = 16'h03E8;
    localparam logic [WORD_W-1:0] INIT_CHG_TIME  = 16'h000A;
    localparam logic [WORD_W-1:0] INIT_PRESET_LO = 16'h03E8;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_LOAD,
        ST_RUN,
        ST_DONE
    } srp_state_t;

    // Word address of one field of one step record
    function automatic logic [ADDR_W-1:0] step_addr(input logic [STEP_W-1:0] step,
                                                    input int fld);
        return ADDR_W'(CTL_HDR + STEP_WORDS * int'(step) + fld);
    endfunction : step_addr

    // Initial content of one control word
    function automatic logic [WORD_W-1:0] init_word(input int idx);
        int rel;
        rel = (idx - CTL_HDR) % STEP_WORDS;
        if (idx == OFS_NSTEPS) return INIT_NSTEPS;
        if (idx == OFS_INT_STEP) return INIT_INT_STEP;
        if (rel == FLD_FREQ) return INIT_FREQ;
        if (rel == FLD_CHG_TIME) return INIT_CHG_TIME;
        if (rel == FLD_PRESET_LO) return INIT_PRESET_LO;
        return 16'h0000;
    endfunction : init_word

endpackage : srp_pkg

`default_nettype wire

//--- rtl/srp_pulse_gen.sv
`timescale 1ns/1ns
`default_nettype none

module srp_pulse_gen #(
    parameter int CLK_HZ = srp_pkg::REF_CLK_HZ,
    parameter int FREQ_W = srp_pkg::WORD_W
) (
    input  wire logic              ref_clk,
    input  wire logic              rst,
    input  wire logic              en,
    input  wire logic [FREQ_W-1:0] freq_hz,
    output logic                   pulse_o,
    output logic                   rise_o
);

    localparam int ACC_W = 28;
    localparam logic [ACC_W-1:0] LIMIT = ACC_W'(CLK_HZ);

    logic [ACC_W-1:0] acc_r;
    wire  [ACC_W-1:0] acc_sum = acc_r + ACC_W'({freq_hz, 1'b0});
    wire              wrap    = (acc_sum >= LIMIT);

    // Phase accumulator toggles twice per period; disabling drops the pin at once
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            acc_r   <= '0;
            pulse_o <= 1'b0;
            rise_o  <= 1'b0;
        end else if (!en) begin
            acc_r   <= '0;
            pulse_o <= 1'b0;
            rise_o  <= 1'b0;
        end else begin
            acc_r   <= wrap ? acc_sum - LIMIT : acc_sum;
            pulse_o <= wrap ? ~pulse_o : pulse_o;
            rise_o  <= wrap & ~pulse_o;
        end
    end

endmodule : srp_pulse_gen

`default_nettype wire

//--- rtl/srp_stepped_ramp_block.sv
`timescale 1ns/1ns
`default_nettype none

module srp_stepped_ramp_block #(
    parameter int CLK_HZ    = srp_pkg::REF_CLK_HZ,
    parameter int MAX_STEPS = srp_pkg::MAX_STEPS
) (
    input  wire logic                                               ref_clk,
    input  wire logic                                               rst,
    input  wire logic                                               scan_tick,
    input  wire logic [srp_pkg::NUM_PORTS-1:0]                      run_in,
    input  wire logic [srp_pkg::NUM_PORTS-1:0]                      init_load_input,
    input  wire logic [srp_pkg::NUM_PORTS-1:0]                      int_in,
    input  wire logic                                               cfg_we,
    input  wire logic                                               cfg_port,
    input  wire logic [srp_pkg::ADDR_W-1:0]                         cfg_addr,
    input  wire logic [srp_pkg::WORD_W-1:0]                         cfg_data,
    input  wire logic                                               mon_port,
    input  wire logic [srp_pkg::MON_IDX_W-1:0]                      mon_idx,
    output logic      [srp_pkg::NUM_PORTS-1:0]                      pulse_out,
    output logic      [srp_pkg::NUM_PORTS-1:0]                      done_out,
    output logic      [srp_pkg::NUM_PORTS*srp_pkg::STAT_BITS-1:0]   status_out,
    output logic      [srp_pkg::WORD_W-1:0]                         mon_data
);

    localparam int NP = srp_pkg::NUM_PORTS;
    localparam int W  = srp_pkg::WORD_W;
    localparam int CW = srp_pkg::CTL_WORDS;
    localparam int MW = srp_pkg::MON_WORDS;
    localparam logic [W-1:0] STEP_LIMIT = W'(MAX_STEPS);

    // Monitor words of both ports, read through one registered window
    logic [W-1:0] mon_w [NP][MW];

    wire mon_in_range = (int'(mon_idx) < MW);

    // Monitor read-out, registered so the port comes from a flop
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            mon_data <= 16'h0000;
        end else begin
            mon_data <= mon_in_range ? mon_w[mon_port][mon_idx] : 16'h0000;
        end
    end

    // One complete engine per pulse output port (ramp_port_a, ramp_port_b)
    for (genvar g = 0; g < NP; g++) begin : g_port
        logic [W-1:0]              ctl_r [CW];
        srp_pkg::srp_state_t       state_r;
        logic [srp_pkg::STEP_W-1:0] step_r;
        logic [srp_pkg::CNT_W-1:0] cnt_r;
        logic [srp_pkg::CNT_W-1:0] preset_r;
        logic [W-1:0]              freq_r;
        logic [W-1:0]              chg_time_r;
        logic                      run_s_r;
        logic                      int_s_r;
        logic                      int_evt_r;
        logic                      init_evt_r;
        logic                      done_r;
        logic                      err_r;
        logic                      int_seen_r;
        logic [srp_pkg::STAT_BITS-1:0] status_r;
        logic                      pulse_w;
        logic                      rise_w;

        // Header and step-record decode
        wire [W-1:0] nsteps    = ctl_r[srp_pkg::OFS_NSTEPS];
        wire [W-1:0] int_step  = ctl_r[srp_pkg::OFS_INT_STEP];
        wire         cfg_ok    = (nsteps != 16'h0000) && (nsteps <= STEP_LIMIT);
        wire         int_ok    = (int_step != 16'h0000) && (int_step <= nsteps);
        wire [W-1:0] step_next = W'(step_r) + 16'h0001;
        wire [W-1:0] f_freq    = ctl_r[srp_pkg::step_addr(step_r, srp_pkg::FLD_FREQ)];
        wire [W-1:0] f_chg     = ctl_r[srp_pkg::step_addr(step_r, srp_pkg::FLD_CHG_TIME)];
        wire [W-1:0] f_pre_hi  = ctl_r[srp_pkg::step_addr(step_r, srp_pkg::FLD_PRESET_HI)];
        wire [W-1:0] f_pre_lo  = ctl_r[srp_pkg::step_addr(step_r, srp_pkg::FLD_PRESET_LO)];
        wire         step_bad  = (f_freq == 16'h0000) || ({f_pre_hi, f_pre_lo} == 32'h0);
        wire         cnt_hit   = rise_w && ((cnt_r + 32'h1) == preset_r);
        wire         last_step = (step_next == nsteps);
        wire         cfg_hit   = cfg_we && (cfg_port == 1'(g)) && (int'(cfg_addr) < CW);

        // Inputs looked at only on the scan tick; edges compare successive scans
        always_ff @(posedge ref_clk or posedge rst) begin
            if (rst) begin
                run_s_r    <= 1'b0;
                int_s_r    <= 1'b0;
                int_evt_r  <= 1'b0;
                init_evt_r <= 1'b0;
            end else begin
                run_s_r    <= scan_tick ? run_in[g] : run_s_r;
                int_s_r    <= scan_tick ? int_in[g] : int_s_r;
                int_evt_r  <= scan_tick & int_in[g] & ~int_s_r;
                init_evt_r <= scan_tick & init_load_input[g];
            end
        end

        // Control block: initial load wins over a configuration write
        always_ff @(posedge ref_clk or posedge rst) begin
            if (rst) begin
                for (int i = 0; i < CW; i++) ctl_r[i] <= srp_pkg::init_word(i);
            end else if (init_evt_r) begin
                for (int i = 0; i < CW; i++) ctl_r[i] <= srp_pkg::init_word(i);
            end else if (cfg_hit) begin
                ctl_r[cfg_addr] <= cfg_data;
            end
        end

        // Step sequencer; a stopped run keeps the completion flag until restarted
        always_ff @(posedge ref_clk or posedge rst) begin
            if (rst) begin
                state_r    <= srp_pkg::ST_IDLE;
                step_r     <= '0;
                cnt_r      <= '0;
                preset_r   <= '0;
                freq_r     <= '0;
                chg_time_r <= '0;
                done_r     <= 1'b0;
                err_r      <= 1'b0;
                int_seen_r <= 1'b0;
            end else if (!run_s_r) begin
                state_r <= srp_pkg::ST_IDLE;
            end else begin
                case (state_r)
                    srp_pkg::ST_IDLE: begin
                        step_r     <= '0;
                        done_r     <= 1'b0;
                        int_seen_r <= 1'b0;
                        err_r      <= ~cfg_ok;
                        state_r    <= cfg_ok ? srp_pkg::ST_LOAD : srp_pkg::ST_DONE;
                    end
                    srp_pkg::ST_LOAD: begin
                        // Settings are copied here so later edits cannot disturb the step
                        preset_r   <= {f_pre_hi, f_pre_lo};
                        freq_r     <= f_freq;
                        chg_time_r <= f_chg;
                        cnt_r      <= '0;
                        err_r      <= step_bad;
                        state_r    <= step_bad ? srp_pkg::ST_DONE : srp_pkg::ST_RUN;
                    end
                    srp_pkg::ST_RUN: begin
                        if (int_evt_r && int_ok) begin
                            step_r     <= srp_pkg::STEP_W'(int_step - 16'h0001);
                            int_seen_r <= 1'b1;
                            state_r    <= srp_pkg::ST_LOAD;
                        end else if (cnt_hit && last_step) begin
                            cnt_r   <= cnt_r + 32'h1;
                            done_r  <= 1'b1;
                            state_r <= srp_pkg::ST_DONE;
                        end else if (cnt_hit) begin
                            step_r  <= srp_pkg::STEP_W'(step_next);
                            state_r <= srp_pkg::ST_LOAD;
                        end else if (rise_w) begin
                            cnt_r <= cnt_r + 32'h1;
                        end
                    end
                    srp_pkg::ST_DONE: begin
                        state_r <= srp_pkg::ST_DONE;
                    end
                    default: begin
                        state_r <= srp_pkg::ST_IDLE;
                    end
                endcase
            end
        end

        // Pulse source runs only in the counting state
        srp_pulse_gen #(
            .CLK_HZ (CLK_HZ),
            .FREQ_W (W)
        ) u_pulse (
            .ref_clk (ref_clk),
            .rst     (rst),
            .en      (run_s_r && (state_r == srp_pkg::ST_RUN)),
            .freq_hz (freq_r),
            .pulse_o (pulse_w),
            .rise_o  (rise_w)
        );

        // Five status flags; direction is fixed forward as no reversible mode exists here
        always_ff @(posedge ref_clk or posedge rst) begin
            if (rst) begin
                status_r <= '0;
            end else begin
                status_r[srp_pkg::STB_OUT_ON]   <= (state_r == srp_pkg::ST_RUN) && run_s_r;
                status_r[srp_pkg::STB_DIR]      <= 1'b0;
                status_r[srp_pkg::STB_COMPLETE] <= done_r;
                status_r[srp_pkg::STB_ERROR]    <= err_r;
                status_r[srp_pkg::STB_INT_SEEN] <= int_seen_r;
            end
        end

        assign pulse_out[g] = pulse_w;
        assign done_out[g]  = done_r;
        assign status_out[g*srp_pkg::STAT_BITS +: srp_pkg::STAT_BITS] = status_r;

        // Nine monitor words of this port
        assign mon_w[g][srp_pkg::MON_STEP]      = W'(step_r) + 16'h0001;
        assign mon_w[g][srp_pkg::MON_CNT_HI]    = cnt_r[31:16];
        assign mon_w[g][srp_pkg::MON_CNT_LO]    = cnt_r[15:0];
        assign mon_w[g][srp_pkg::MON_PRESET_HI] = preset_r[31:16];
        assign mon_w[g][srp_pkg::MON_PRESET_LO] = preset_r[15:0];
        assign mon_w[g][srp_pkg::MON_FREQ]      = freq_r;
        assign mon_w[g][srp_pkg::MON_CHG_TIME]  = chg_time_r;
        assign mon_w[g][srp_pkg::MON_NSTEPS]    = nsteps;
        assign mon_w[g][srp_pkg::MON_INT_STEP]  = int_step;
    end

endmodule : srp_stepped_ramp_block

`default_nettype wire

//--- tb/srp_checker_properties.sv
`timescale 1ns/1ns
`default_nettype none

module srp_checker (
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic        scan_tick,
    input wire logic [1:0]  run_in,
    input wire logic [3:0]  mon_idx,
    input wire logic [1:0]  pulse_out,
    input wire logic [1:0]  done_out,
    input wire logic [9:0]  status_out,
    input wire logic [15:0] mon_data
);
    // One domain, so clock and reset are declared once
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    // Stop must win within two edges, or the drive keeps stepping
    stop_port_a_a: assert property (scan_tick && !run_in[0] |-> ##2 !pulse_out[0])
        else $error("port a still pulsing after stop");
    stop_port_b_a: assert property (scan_tick && !run_in[1] |-> ##2 !pulse_out[1])
        else $error("port b still pulsing after stop");
    done_hold_a: assert property ($rose(done_out[0]) |=> done_out[0] [*8])
        else $error("completion dropped");
    done_flag_a: assert property ($rose(done_out[0]) |=> status_out[2])
        else $error("complete flag missing");
    done_quiet_a: assert property (done_out[0] |-> ##1 !pulse_out[0])
        else $error("pulses after completion");
    mon_range_a: assert property (mon_idx >= 4'h9 |=> mon_data == 16'h0000)
        else $error("monitor word beyond nine not zero");
    dir_flag_a: assert property (!status_out[1] && !status_out[6])
        else $error("direction flag set");
    err_no_done_a: assert property (status_out[8] |-> !done_out[1])
        else $error("completion with bad step count");

    // Main scenarios reached
    cover property ($rose(done_out[0]));
    cover property ($rose(done_out[1]));
    cover property ($rose(status_out[8]));
endmodule : srp_checker

bind srp_stepped_ramp_block srp_checker u_chk (
    .ref_clk(ref_clk), .rst(rst), .scan_tick(scan_tick), .run_in(run_in),
    .mon_idx(mon_idx), .pulse_out(pulse_out), .done_out(done_out),
    .status_out(status_out), .mon_data(mon_data)
);

`default_nettype wire

//--- tb/srp_motor_model.sv
`timescale 1ns/1ns
`default_nettype none

module srp_motor_model (
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire logic       clr,
    input  wire logic [1:0] pulse_in,
    output var logic [31:0] pos_a,
    output var logic [31:0] pos_b
);
    logic [1:0] last_r;

    // One rise is one motor step; each port moves its own axis
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            last_r <= 2'h0;
            pos_a  <= 32'h0;
            pos_b  <= 32'h0;
        end else begin
            last_r <= pulse_in;
            pos_a  <= clr ? 32'h0 : pos_a + 32'(pulse_in[0] & ~last_r[0]);
            pos_b  <= clr ? 32'h0 : pos_b + 32'(pulse_in[1] & ~last_r[1]);
        end
    end
endmodule : srp_motor_model

`default_nettype wire

//--- tb/stepped_ramp_pulse_output_tb_top.sv
`timescale 1ns/1ns
`default_nettype none

module stepped_ramp_pulse_output_tb_top;
    localparam int CLK_HZ = 8000; // 1 kHz gives a four-cycle half period

    logic        ref_clk, rst, scan_tick, cfg_we, cfg_port, mon_port, clr;
    logic [1:0]  run_in, init_load_input, int_in, pulse_out, done_out, scan_cnt;
    logic [6:0]  cfg_addr;
    logic [15:0] cfg_data, mon_data, rd_v;
    logic [3:0]  mon_idx;
    logic [9:0]  status_out;
    logic [31:0] pos_a, pos_b, base_v;
    int          n_errors, compares;

    srp_stepped_ramp_block #(.CLK_HZ(CLK_HZ)) dut (
        .ref_clk(ref_clk), .rst(rst), .scan_tick(scan_tick), .run_in(run_in),
        .init_load_input(init_load_input), .int_in(int_in), .cfg_we(cfg_we),
        .cfg_port(cfg_port), .cfg_addr(cfg_addr), .cfg_data(cfg_data),
        .mon_port(mon_port), .mon_idx(mon_idx), .pulse_out(pulse_out),
        .done_out(done_out), .status_out(status_out), .mon_data(mon_data)
    );

    srp_motor_model mdl (
        .ref_clk(ref_clk), .rst(rst), .clr(clr), .pulse_in(pulse_out),
        .pos_a(pos_a), .pos_b(pos_b)
    );

    // Clock, and a scan every fourth cycle
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        scan_cnt  <= scan_cnt + 2'h1;
        scan_tick <= (scan_cnt == 2'h2);
    end

    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : summarize

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic p, input logic [6:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        {cfg_we, cfg_port, cfg_addr, cfg_data} <= {1'b1, p, a, d};
        @(posedge ref_clk);
        cfg_we <= 1'b0;
    endtask : wr

    // Monitor word is registered, so read after the second edge
    task automatic rd(input logic p, input logic [3:0] i);
        @(posedge ref_clk);
        {mon_port, mon_idx} <= {p, i};
        repeat (2) @(posedge ref_clk);
        #1 rd_v = mon_data;
    endtask : rd

    // Two steps only; block end stays far below the top word
    task automatic cfg(input logic p, input logic [15:0] n, s, f0, l0, f1, l1);
        wr(p, 7'h00, n);
        wr(p, 7'h01, s);
        wr(p, 7'h02, f0);
        wr(p, 7'h05, l0);
        wr(p, 7'h08, f1);
        wr(p, 7'h0B, l1);
    endtask : cfg

    task automatic scans(input int k);
        repeat (4 * k) @(posedge ref_clk);
    endtask : scans

    task automatic clear();
        @(posedge ref_clk);
        clr <= 1'b1;
        @(posedge ref_clk);
        clr <= 1'b0;
    endtask : clear

    // Bounded wait for completion on port p
    task automatic wait_done(input int p);
        int i;
        for (i = 0; i < 20000 && done_out[p] !== 1'b1; i++) @(posedge ref_clk);
        if (i == 20000) begin
            n_errors++;
            summarize();
        end
        #1;
    endtask : wait_done

    task automatic wait_b(input logic v);
        int i;
        for (i = 0; i < 99 && pulse_out[1] !== v; i++) begin
            @(posedge ref_clk);
            #1;
        end
        if (i == 99) begin
            n_errors++;
            summarize();
        end
    endtask : wait_b

    initial begin
        {rst, scan_tick, cfg_we, cfg_port, mon_port, clr} = 6'h20;
        {run_in, init_load_input, int_in, scan_cnt} = 8'h00;
        {cfg_addr, cfg_data, mon_idx} = 27'h0;
        n_errors = 0;
        compares = 0;
        repeat (9) @(posedge ref_clk);
        #1 chk({pulse_out, done_out, status_out}, 32'h0);
        @(posedge ref_clk);
        rst <= 1'b0;
        rd(1'b0, 4'h9);
        chk(rd_v, 32'h0);
        // Two-step run; edit of the running step must not apply
        cfg(1'b0, 16'h0002, 16'h0001, 16'h03E8, 16'h0003, 16'h07D0, 16'h0002);
        @(posedge ref_clk);
        run_in[0] <= 1'b1;
        scans(2);
        wr(1'b0, 7'h05, 16'h0009);
        wait_done(0);
        chk(pos_a, 32'h5);
        rd(1'b0, 4'h0);
        chk(rd_v, 32'h2);
        scans(3);
        chk({done_out[0], status_out[2]}, 32'h3);
        // Reload initial values while stopped, then run them
        @(posedge ref_clk);
        {run_in[0], init_load_input[0]} <= 2'b01;
        scans(2);
        init_load_input[0] <= 1'b0;
        clear();
        run_in[0] <= 1'b1;
        scans(4);
        chk(done_out[0], 32'h0);
        wait_done(0);
        chk(pos_a, 32'd1000);
        // Stop in mid-step: no steps after the stop settles
        @(posedge ref_clk);
        run_in[0] <= 1'b0;
        scans(2);
        run_in[0] <= 1'b1;
        scans(20);
        run_in[0] <= 1'b0;
        // A rise launched on the sampling scan still reaches the motor
        scans(2);
        #1 base_v = pos_a;
        scans(5);
        chk(pos_a - base_v, 32'h0);
        chk(pulse_out[0], 32'h0);
        // Port b interrupt jumps to step two, port a unaffected
        cfg(1'b1, 16'h0002, 16'h0002, 16'h01F4, 16'h0064, 16'h03E8, 16'h0003);
        @(posedge ref_clk);
        run_in[1] <= 1'b1;
        scans(10);
        wait_b(1'b0);
        wait_b(1'b1);
        @(posedge ref_clk);
        int_in[1] <= 1'b1;
        #1 base_v = pos_b;
        scans(2);
        int_in[1] <= 1'b0;
        wait_done(1);
        chk(pos_b - base_v, 32'h3);
        chk({status_out[9], done_out[0]}, 32'h2);
        // Nineteen steps is refused with the error flag
        @(posedge ref_clk);
        run_in[1] <= 1'b0;
        scans(2);
        wr(1'b1, 7'h00, 16'h0013);
        clear();
        run_in[1] <= 1'b1;
        scans(6);
        chk({status_out[8], done_out[1]}, 32'h2);
        chk(pos_b, 32'h0);
        summarize();
    end
endmodule : stepped_ramp_pulse_output_tb_top

`default_nettype wire
